// ### design/ccemd_pkg.sv
// Constants, types and helpers for the extended core datapath.
// Assumes a single 20 MHz clock and the documented SFR port.
// Summary of operation
// - External interrupt zero vectors to 0003H, enabled by enable bit 0, pin falling edge.
// - Timer zero 000BH, timer one 001BH, capture 0023H, enable bits 1, 3, 4.
// - Endpoint-0 setup, overwrite, error, IN, OUT vector 0043H..0063H, second enable bits 0-4.
// - Serial engine causes share 006BH (bit 5); suspend or overflow use 0073H (bit 6).
// - Unmapped SFR reads return 00h; unmapped writes change nothing.
// - Stack pointer resets to 07H; software may reload it freely.
// - Bank bits choose register bank base 00H, 08H, 10H or 18H.
// - Parity bit tracks accumulator so that the total ones count is even.
// - Status word holds carry, half carry, user flag, overflow and user bit.
// - Accumulator, B and status word reset to 00h.
// - Each data pointer is 16 bits, also reachable as two bytes.
// - Multiply is 8x8, or with mode bit 2 set 16x8 using the extension byte.
// - Divide is 8/8, or with mode bit 3 set 16/8 using the extension byte.
// - Hardware or USB reset clears the mode control bits.
// - Mode bit 0 selects the secondary pointer; pointer operations use the selected one.
// - Secondary pointer bytes sit at 84H and 85H, each read/write.
// - Multiply and divide take 11 cycles, or 20 cycles in 16-bit mode.
// - Register arithmetic 1 cycle, memory arithmetic 2, pointer increment and swap 4.
// - Operations follow standard semantics apart from cycle counts and the extension.
package ccemd_pkg;

  // ----------------------------------------------------------------
  // SFR addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_ALT_POINTER_LOW_BYTE = 8'h84;
  localparam logic [7:0] SFR_ALT_POINTER_HIGH_BYTE = 8'h85;
  localparam logic [7:0] SFR_MODE = 8'h86;
  localparam logic [7:0] SFR_IEN1 = 8'ha8;
  localparam logic [7:0] SFR_IEN2 = 8'ha9;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_IFL1 = 8'hda;
  localparam logic [7:0] SFR_IFL2 = 8'hdb;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B = 8'hf0;
  localparam logic [7:0] SFR_EXT = 8'hf1;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h0d;
  localparam logic [7:0] IEN1_WMASK = 8'h9b;
  localparam logic [7:0] IEN2_WMASK = 8'h7f;
  localparam int MODE_DPSEL = 0;
  localparam int MODE_MUL16 = 2;
  localparam int MODE_DIV16 = 3;
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_OV = 2;
  localparam int IEN_EA = 7;
  localparam int NSLOT = 15;
  localparam logic [15:0] VEC_BASE = 16'h0003;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [4:0] CYC_MD8 = 5'h0b;
  localparam logic [4:0] CYC_MD16 = 5'h14;
  localparam logic [4:0] CYC_REG = 5'h01;
  localparam logic [4:0] CYC_MEM = 5'h02;
  localparam logic [4:0] CYC_SLOW = 5'h04;
  localparam logic [4:0] CYC_RETI = 5'h08;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_SUBB, OP_INCA, OP_DECA, OP_ANL, OP_ORL,
    OP_XRL, OP_CLRA, OP_CPLA, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP,
    OP_DA, OP_MUL, OP_DIV, OP_INCDP, OP_MOVA, OP_RETI, OP_CLRC, OP_SETC,
    OP_CPLC
  } ccemd_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_MDIV = 2'b11
  } ccemd_state_t;

  // Vector of an interrupt slot: eight bytes apart from 0003H
  function automatic logic [15:0] slot_vector(input logic [3:0] slot);
    slot_vector = VEC_BASE + {9'h000, slot, 3'h0};
  endfunction : slot_vector

endpackage : ccemd_pkg

// ### design/ccemd_md_if.sv
// Link between the core datapath and its multiply/divide unit.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface ccemd_md_if;
  logic start;
  logic is_div;
  logic wide;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] x;
  logic done;
  logic [7:0] res_a;
  logic [7:0] res_b;
  logic [7:0] res_x;
  logic ovf;
  modport core (output start, is_div, wide, a, b, x,
                input done, res_a, res_b, res_x, ovf);
  modport unit (input start, is_div, wide, a, b, x,
                output done, res_a, res_b, res_x, ovf);
endinterface : ccemd_md_if
`default_nettype wire

// ### design/ccemd_muldiv.sv
// Multiply/divide unit with documented latency.
// Assumes operands stay valid only in the start cycle.
`timescale 1ns/1ps
`default_nettype none
module ccemd_muldiv
  import ccemd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  ccemd_md_if.unit md
);
  logic [15:0] num;
  logic [23:0] prod;
  logic [15:0] quo;
  logic [7:0] rem;
  logic [4:0] cnt_q;
  logic run_q;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  always_comb
  begin
    num = md.wide ? {md.x, md.a} : {8'h00, md.a};
    prod = num * {16'h0000, md.b};
    quo = (md.b == 8'h00) ? 16'h0000 : num / {8'h00, md.b};
    rem = (md.b == 8'h00) ? 8'h00 : 8'((num % {8'h00, md.b}));
  end

  // Result captured at start; latency is modelled by the counter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      md.res_a <= 8'h00;
      md.res_b <= 8'h00;
      md.res_x <= 8'h00;
      md.ovf <= 1'b0;
    end
    else if (md.start && !md.is_div)
    begin
      md.res_a <= prod[7:0];
      md.res_b <= prod[15:8];
      md.res_x <= md.wide ? prod[23:16] : md.x;
      md.ovf <= md.wide ? (prod[23:16] != 8'h00) : (prod[15:8] != 8'h00);
    end
    else if (md.start)
    begin
      md.res_a <= (md.b == 8'h00) ? md.a : quo[7:0];
      md.res_b <= (md.b == 8'h00) ? md.b : rem;
      md.res_x <= (md.wide && md.b != 8'h00) ? quo[15:8] : md.x;
      md.ovf <= (md.b == 8'h00);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 5'h00;
      run_q <= 1'b0;
      md.done <= 1'b0;
    end
    else
    begin
      md.done <= 1'b0;
      if (md.start)
      begin
        cnt_q <= (md.wide ? CYC_MD16 : CYC_MD8) - 5'h02;
        run_q <= 1'b1;
      end
      else if (run_q && cnt_q == 5'h00)
      begin
        run_q <= 1'b0;
        md.done <= 1'b1;
      end
      else if (run_q)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule : ccemd_muldiv
`default_nettype wire

// ### design/ccemd_core.sv
// Core register file, ALU, multiply/divide extension and vectoring.
// Assumes an external sequencer issues operations and fetches operands.
`timescale 1ns/1ps
`default_nettype none
module ccemd_core
  import ccemd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic usb_reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic op_valid,
  input wire ccemd_pkg::ccemd_op_t op_code,
  input wire logic op_src_mem,
  input wire logic [7:0] op_operand,
  output logic op_busy,
  output logic op_done,
  output logic [15:0] sel_pointer,
  output logic [7:0] bank_base,
  output logic [7:0] stack_top,
  input wire logic external_irq_pin,
  input wire logic timer_zero_evt,
  input wire logic timer_one_evt,
  input wire logic capture_evt,
  input wire logic [4:0] ep0_evt,
  input wire logic [7:0] serial_engine_cause,
  input wire logic [1:0] suspend_overflow_cause,
  input wire logic irq_take,
  output logic irq_req,
  output logic [15:0] irq_vector
);
  import ccemd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] acc_q, b_q, ext_q, sp_q, mode_q, ien1_q, ien2_q, ifl1_q, ifl2_q;
  logic [7:0] dpl_q, dph_q, alt_pointer_low_byte_q, alt_pointer_high_byte_q;
  logic cy_q, ac_q, f0_q, ov_q, ubit_q, par_q;
  logic [1:0] bank_q;
  ccemd_state_t st_q;
  ccemd_op_t opr_q;
  logic [7:0] opd_q;
  logic [4:0] cnt_q;
  logic sync1_q, sync2_q, sync3_q, pin_lvl_q;
  logic op_acc, commit, md_commit, wr_hit, ext_fall;
  logic [7:0] acc_n, psw_rd;
  logic cy_n, ac_n, ov_n;
  logic [8:0] sum;
  logic [15:0] dp_inc;
  logic [NSLOT-1:0] pend;
  logic [3:0] top_slot;
  logic any_pend;

  ccemd_md_if md ();

  ccemd_muldiv u_md (
    .clk(clk),
    .resetn(resetn),
    .md(md)
  );

  function automatic logic [4:0] op_cycles(input ccemd_op_t op, input logic mem);
    case (op)
      OP_ADD, OP_ADDC, OP_SUBB, OP_ANL, OP_ORL, OP_XRL, OP_MOVA:
        op_cycles = mem ? CYC_MEM : CYC_REG;
      OP_SWAP, OP_INCDP: op_cycles = CYC_SLOW;
      OP_RETI: op_cycles = CYC_RETI;
      default: op_cycles = CYC_REG;
    endcase
  endfunction : op_cycles

  assign op_acc = op_valid && st_q == ST_IDLE;
  assign commit = st_q == ST_EXEC && cnt_q == 5'h00;
  assign md_commit = st_q == ST_MDIV && md.done;
  assign wr_hit = sfr_wr && !commit && !md_commit;
  assign psw_rd = {cy_q, ac_q, f0_q, bank_q, ov_q, ubit_q, par_q};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      opr_q <= OP_NOP;
      opd_q <= 8'h00;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (op_acc)
          begin
            opr_q <= op_code;
            opd_q <= op_operand;
            cnt_q <= op_cycles(op_code, op_src_mem) - 5'h01;
            st_q <= (op_code == OP_MUL || op_code == OP_DIV) ? ST_MDIV : ST_EXEC;
          end
        ST_EXEC:
          if (cnt_q == 5'h00)
            st_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 5'h01;
        ST_MDIV:
          if (md.done)
            st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    md.start = op_acc && (op_code == OP_MUL || op_code == OP_DIV);
    md.is_div = op_code == OP_DIV;
    md.wide = (op_code == OP_DIV) ? mode_q[MODE_DIV16] : mode_q[MODE_MUL16];
    md.a = acc_q;
    md.b = b_q;
    md.x = ext_q;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_busy <= 1'b0;
      op_done <= 1'b0;
    end
    else
    begin
      op_busy <= op_acc || (op_busy && !commit && !md_commit);
      op_done <= commit || md_commit;
    end
  end

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_n = acc_q;
    cy_n = cy_q;
    ac_n = ac_q;
    ov_n = ov_q;
    sum = 9'h000;
    dp_inc = (mode_q[MODE_DPSEL] ? {alt_pointer_high_byte_q, alt_pointer_low_byte_q} : {dph_q, dpl_q}) + 16'h0001;
    case (opr_q)
      OP_ADD, OP_ADDC:
      begin
        sum = {1'b0, acc_q} + {1'b0, opd_q} + {8'h00, opr_q == OP_ADDC && cy_q};
        acc_n = sum[7:0];
        cy_n = sum[8];
        ac_n = ({1'b0, acc_q[3:0]} + {1'b0, opd_q[3:0]}
               + {4'h0, opr_q == OP_ADDC && cy_q}) > 5'h0f;
        ov_n = (acc_q[7] == opd_q[7]) && (sum[7] != acc_q[7]);
      end
      OP_SUBB:
      begin
        sum = {1'b0, acc_q} - {1'b0, opd_q} - {8'h00, cy_q};
        acc_n = sum[7:0];
        cy_n = sum[8];
        ac_n = {1'b0, acc_q[3:0]} < ({1'b0, opd_q[3:0]} + {4'h0, cy_q});
        ov_n = (acc_q[7] != opd_q[7]) && (sum[7] != acc_q[7]);
      end
      OP_INCA: acc_n = acc_q + 8'h01;
      OP_DECA: acc_n = acc_q - 8'h01;
      OP_ANL: acc_n = acc_q & opd_q;
      OP_ORL: acc_n = acc_q | opd_q;
      OP_XRL: acc_n = acc_q ^ opd_q;
      OP_CLRA: acc_n = 8'h00;
      OP_CPLA: acc_n = ~acc_q;
      OP_RL: acc_n = {acc_q[6:0], acc_q[7]};
      OP_RR: acc_n = {acc_q[0], acc_q[7:1]};
      OP_RLC:
      begin
        acc_n = {acc_q[6:0], cy_q};
        cy_n = acc_q[7];
      end
      OP_RRC:
      begin
        acc_n = {cy_q, acc_q[7:1]};
        cy_n = acc_q[0];
      end
      OP_SWAP: acc_n = {acc_q[3:0], acc_q[7:4]};
      OP_DA:
      begin
        sum = {1'b0, acc_q};
        if (ac_q || acc_q[3:0] > 4'h9)
          sum = sum + 9'h006;
        if (cy_q || sum[8] || sum[7:4] > 4'h9)
          sum = sum + 9'h060;
        acc_n = sum[7:0];
        cy_n = cy_q | sum[8];
      end
      OP_MOVA: acc_n = opd_q;
      OP_CLRC: cy_n = 1'b0;
      OP_SETC: cy_n = 1'b1;
      OP_CPLC: cy_n = ~cy_q;
      default: acc_n = acc_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Accumulator, B, extension byte, status word
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_q <= ZERO8;
      b_q <= ZERO8;
      ext_q <= ZERO8;
    end
    else if (md_commit)
    begin
      acc_q <= md.res_a;
      b_q <= md.res_b;
      ext_q <= md.res_x;
    end
    else if (commit)
      acc_q <= acc_n;
    else if (wr_hit)
    begin
      if (sfr_addr == SFR_ACC)
        acc_q <= sfr_wdata;
      if (sfr_addr == SFR_B)
        b_q <= sfr_wdata;
      if (sfr_addr == SFR_EXT)
        ext_q <= sfr_wdata;
    end
  end

  // Status word: parity is not writable, it follows the accumulator
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {cy_q, ac_q, f0_q, bank_q, ov_q, ubit_q} <= 7'h00;
      par_q <= 1'b0;
    end
    else
    begin
      par_q <= ^acc_q;
      if (md_commit)
      begin
        cy_q <= 1'b0;
        ov_q <= md.ovf;
      end
      else if (commit)
      begin
        cy_q <= cy_n;
        ac_q <= ac_n;
        ov_q <= ov_n;
      end
      else if (wr_hit && sfr_addr == SFR_PSW)
        {cy_q, ac_q, f0_q, bank_q, ov_q, ubit_q} <= sfr_wdata[7:1];
    end
  end

  // ----------------------------------------------------------------
  // Pointers, stack and mode control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {dph_q, dpl_q, alt_pointer_high_byte_q, alt_pointer_low_byte_q} <= 32'h0000_0000;
    end
    else if (commit && opr_q == OP_INCDP && mode_q[MODE_DPSEL])
      {alt_pointer_high_byte_q, alt_pointer_low_byte_q} <= dp_inc;
    else if (commit && opr_q == OP_INCDP)
      {dph_q, dpl_q} <= dp_inc;
    else if (wr_hit)
    begin
      if (sfr_addr == SFR_DPL)
        dpl_q <= sfr_wdata;
      if (sfr_addr == SFR_DPH)
        dph_q <= sfr_wdata;
      if (sfr_addr == SFR_ALT_POINTER_LOW_BYTE)
        alt_pointer_low_byte_q <= sfr_wdata;
      if (sfr_addr == SFR_ALT_POINTER_HIGH_BYTE)
        alt_pointer_high_byte_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sp_q <= SP_RST;
    else if (irq_take)
      sp_q <= sp_q + 8'h02;
    else if (commit && opr_q == OP_RETI)
      sp_q <= sp_q - 8'h02;
    else if (wr_hit && sfr_addr == SFR_SP)
      sp_q <= sfr_wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode_q <= ZERO8;
    else if (usb_reset)
      mode_q <= ZERO8;
    else if (wr_hit && sfr_addr == SFR_MODE)
      mode_q <= sfr_wdata & MODE_WMASK;
  end

  // ----------------------------------------------------------------
  // Interrupt flags and vectoring
  // ----------------------------------------------------------------
  // Three stages; the first only feeds the second against metastability
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      pin_lvl_q <= 1'b1;
    end
    else
    begin
      sync1_q <= external_irq_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
        pin_lvl_q <= sync3_q;
    end
  end

  assign ext_fall = pin_lvl_q && sync2_q == sync3_q && !sync3_q;

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ifl1_q <= ZERO8;
      ifl2_q <= ZERO8;
    end
    else
    begin
      if (wr_hit && sfr_addr == SFR_IFL1)
        ifl1_q <= sfr_wdata & IEN1_WMASK & 8'h1b;
      else if (irq_take && top_slot == 4'h0)
        ifl1_q[0] <= 1'b0;
      if (wr_hit && sfr_addr == SFR_IFL2)
        ifl2_q <= sfr_wdata & IEN2_WMASK;
      if (ext_fall)
        ifl1_q[0] <= 1'b1;
      if (timer_zero_evt)
        ifl1_q[1] <= 1'b1;
      if (timer_one_evt)
        ifl1_q[3] <= 1'b1;
      if (capture_evt)
        ifl1_q[4] <= 1'b1;
      for (int i = 0; i < 5; i++)
        if (ep0_evt[i])
          ifl2_q[i] <= 1'b1;
      if (|serial_engine_cause)
        ifl2_q[5] <= 1'b1;
      if (|suspend_overflow_cause)
        ifl2_q[6] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ien1_q <= ZERO8;
      ien2_q <= ZERO8;
    end
    else if (wr_hit)
    begin
      if (sfr_addr == SFR_IEN1)
        ien1_q <= sfr_wdata & IEN1_WMASK;
      if (sfr_addr == SFR_IEN2)
        ien2_q <= sfr_wdata & IEN2_WMASK;
    end
  end

  // Lowest vector address wins; priority levels live elsewhere
  always_comb
  begin
    pend = {ifl2_q[6:0] & ien2_q[6:0], ifl1_q & ien1_q & 8'h1b};
    top_slot = 4'h0;
    any_pend = ien1_q[IEN_EA] && |pend;
    for (int i = NSLOT - 1; i >= 0; i--)
      if (pend[i])
        top_slot = 4'(i);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
    end
    else
    begin
      irq_req <= any_pend && !irq_take;
      irq_vector <= slot_vector(top_slot);
    end
  end

  // ----------------------------------------------------------------
  // Read port and registered views
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      case (sfr_addr)
        SFR_SP: sfr_rdata <= sp_q;
        SFR_DPL: sfr_rdata <= dpl_q;
        SFR_DPH: sfr_rdata <= dph_q;
        SFR_ALT_POINTER_LOW_BYTE: sfr_rdata <= alt_pointer_low_byte_q;
        SFR_ALT_POINTER_HIGH_BYTE: sfr_rdata <= alt_pointer_high_byte_q;
        SFR_MODE: sfr_rdata <= mode_q;
        SFR_IEN1: sfr_rdata <= ien1_q;
        SFR_IEN2: sfr_rdata <= ien2_q;
        SFR_PSW: sfr_rdata <= psw_rd;
        SFR_IFL1: sfr_rdata <= ifl1_q;
        SFR_IFL2: sfr_rdata <= ifl2_q;
        SFR_ACC: sfr_rdata <= acc_q;
        SFR_B: sfr_rdata <= b_q;
        SFR_EXT: sfr_rdata <= ext_q;
        default: sfr_rdata <= 8'h00;
      endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_pointer <= 16'h0000;
      bank_base <= 8'h00;
      stack_top <= SP_RST;
    end
    else
    begin
      sel_pointer <= mode_q[MODE_DPSEL] ? {alt_pointer_high_byte_q, alt_pointer_low_byte_q} : {dph_q, dpl_q};
      bank_base <= {3'h0, bank_q, 3'h0};
      stack_top <= sp_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stack_irq_a: assert property (@(posedge clk) disable iff (!resetn)
    irq_take |=> sp_q == $past(sp_q) + 8'h02) else $error("stack not advanced");
  parity_track_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (^{acc_q, psw_rd[0]}) == 1'b0 || $changed(acc_q)) else $error("parity wrong");
  mul8_len_a: assert property (@(posedge clk) disable iff (!resetn)
    op_acc && op_code == OP_MUL && !mode_q[MODE_MUL16] |-> ##12 op_done)
    else $error("8-bit multiply length");
  md16_len_a: assert property (@(posedge clk) disable iff (!resetn)
    op_acc && op_code == OP_DIV && mode_q[MODE_DIV16] |-> ##1 !op_done [*8] ##13 op_done)
    else $error("16-bit divide length");
  reg_arith_a: assert property (@(posedge clk) disable iff (!resetn)
    op_acc && op_code == OP_ADD && !op_src_mem |-> ##2 op_done)
    else $error("register add length");
  swap_len_a: assert property (@(posedge clk) disable iff (!resetn)
    op_acc && op_code == OP_SWAP |-> ##5 op_done && acc_q == {$past(acc_q[3:0], 5),
    $past(acc_q[7:4], 5)}) else $error("swap length or value");
  usb_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    usb_reset |=> mode_q == 8'h00) else $error("mode not cleared");
  unmapped_wr_a: assert property (@(posedge clk) disable iff (!resetn)
    sfr_wr && sfr_addr == 8'hf8 && st_q == ST_IDLE && !irq_take && !usb_reset |=>
    $stable({acc_q, b_q, ext_q, sp_q, mode_q, ien1_q, ien2_q})) else $error("unmapped write");
  ext_vector_a: assert property (@(posedge clk) disable iff (!resetn)
    ien1_q[IEN_EA] && ien1_q[0] && ifl1_q[0] && !irq_take |=>
    irq_req && irq_vector == 16'h0003) else $error("external vector");
endmodule : ccemd_core
`default_nettype wire

// ### tb/tb_ccemd_core.sv
// Bench for the extended core datapath top.
// Assumes a 20 MHz clock and the SFR, operation and event ports.
`timescale 1ns/1ps
`default_nettype none
module tb_ccemd_core;
  import ccemd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic usb_reset = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic op_valid = 1'b0;
  ccemd_op_t op_code = OP_NOP;
  logic op_src_mem = 1'b0;
  logic [7:0] op_operand = 8'h00;
  logic [10:0] ev = 11'h000;
  logic irq_take = 1'b0;
  logic [7:0] sfr_rdata, bank_base, stack_top;
  logic op_busy, op_done, irq_req;
  logic [15:0] sel_pointer, irq_vector;
  logic [7:0] vec [11] = '{8'h03, 8'h0b, 8'h1b, 8'h23, 8'h43, 8'h4b, 8'h53, 8'h5b,
                           8'h63, 8'h6b, 8'h73};
  int n_fail = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  // Event bit 0 drives the pin low, so setting it makes the falling edge
  ccemd_core DUT (.clk, .resetn, .usb_reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata, .op_valid, .op_code, .op_src_mem, .op_operand, .op_busy, .op_done,
    .sel_pointer, .bank_base, .stack_top, .external_irq_pin(~ev[0]),
    .timer_zero_evt(ev[1]), .timer_one_evt(ev[2]), .capture_evt(ev[3]),
    .ep0_evt(ev[8:4]), .serial_engine_cause({8{ev[9]}}),
    .suspend_overflow_cause({2{ev[10]}}), .irq_take, .irq_req, .irq_vector);
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, e);
  endtask : rd
  // Counts edges from the taking edge until the done pulse
  task op(input ccemd_op_t c, input logic m, input logic [7:0] n);
    int k;
    @(posedge clk);
    op_code <= c;
    op_src_mem <= m;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    k = 0;
    #1;
    chk({7'h00, op_busy}, 8'h01);
    while (op_done !== 1'b1 && k < 30)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(8'(k), n);
  endtask : op
  task results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
  initial
  begin
    tk(5);
    resetn <= 1'b1;
    tk(4);
    #1 chk(stack_top, 8'h07);
    rd(SFR_SP, 8'h07);
    rd(SFR_ACC, 8'h00);
    rd(SFR_B, 8'h00);
    rd(SFR_PSW, 8'h00);
    wr(SFR_ALT_POINTER_LOW_BYTE, 8'h34);
    wr(SFR_ALT_POINTER_HIGH_BYTE, 8'h12);
    wr(SFR_MODE, 8'h01);
    rd(SFR_ALT_POINTER_HIGH_BYTE, 8'h12);
    chk(sel_pointer[15:8], 8'h12);
    chk(sel_pointer[7:0], 8'h34);
    usb_reset <= 1'b1;
    tk(1);
    usb_reset <= 1'b0;
    rd(SFR_MODE, 8'h00);
    chk(sel_pointer[15:8], 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(SFR_PSW, 8'(i * 8));
      tk(1);
      #1 chk(bank_base, 8'(i * 8));
    end
    wr(SFR_ACC, 8'h07);
    wr(8'hf8, 8'hff);
    tk(1);
    rd(SFR_PSW, 8'h19);
    rd(SFR_ACC, 8'h07);
    op_operand <= 8'h11;
    op(OP_ADD, 1'b0, 8'h01);
    op(OP_ADD, 1'b1, 8'h02);
    op(OP_SWAP, 1'b0, 8'h04);
    rd(SFR_ACC, 8'h92);
    op(OP_INCDP, 1'b0, 8'h04);
    tk(1);
    #1 chk(sel_pointer[7:0], 8'h01);
    wr(SFR_ACC, 8'h12);
    wr(SFR_B, 8'h34);
    op(OP_MUL, 1'b0, 8'h0b);
    rd(SFR_ACC, 8'ha8);
    rd(SFR_B, 8'h03);
    wr(SFR_MODE, 8'hff);
    rd(SFR_MODE, 8'h0d);
    wr(SFR_EXT, 8'h12);
    wr(SFR_ACC, 8'h34);
    wr(SFR_B, 8'h56);
    op(OP_MUL, 1'b0, 8'h14);
    rd(SFR_ACC, 8'h78);
    rd(SFR_B, 8'h1d);
    rd(SFR_EXT, 8'h06);
    wr(SFR_EXT, 8'h12);
    wr(SFR_ACC, 8'h34);
    wr(SFR_B, 8'h10);
    op(OP_DIV, 1'b0, 8'h14);
    rd(SFR_ACC, 8'h23);
    rd(SFR_B, 8'h04);
    rd(SFR_EXT, 8'h01);
    wr(SFR_MODE, 8'h00);
    wr(SFR_ACC, 8'h64);
    wr(SFR_B, 8'h07);
    op(OP_DIV, 1'b0, 8'h0b);
    rd(SFR_ACC, 8'h0e);
    rd(SFR_B, 8'h02);
    rd(SFR_EXT, 8'h01);
    wr(SFR_B, 8'h00);
    op(OP_DIV, 1'b0, 8'h0b);
    rd(SFR_PSW, 8'h1d);
    wr(SFR_IEN1, 8'h9b);
    wr(SFR_IEN2, 8'h7f);
    for (int i = 0; i < 11; i++)
    begin
      ev <= 11'h001 << i;
      tk(3);
      ev <= 11'h000;
      tk(6);
      #1 chk(irq_vector[7:0], vec[i]);
      chk({7'h00, irq_req}, 8'h01);
      wr(SFR_IFL1, 8'h00);
      wr(SFR_IFL2, 8'h00);
      tk(2);
    end
    wr(SFR_IEN1, 8'h80);
    ev <= 11'h002;
    tk(3);
    ev <= 11'h000;
    tk(4);
    #1 chk({7'h00, irq_req}, 8'h00);
    wr(SFR_IEN1, 8'h82);
    tk(3);
    irq_take <= 1'b1;
    tk(1);
    irq_take <= 1'b0;
    tk(2);
    #1 chk(stack_top, 8'h09);
    results();
  end
endmodule : tb_ccemd_core
`default_nettype wire
